/* rya_defs.svh */
`ifndef RYA_DEFS_SVH
`define RYA_DEFS_SVH

// ********************************************************************
// Register byte offsets.
// ********************************************************************
`define RYA_OFS_YEAR       8'h00
`define RYA_OFS_ALARM0     8'h04
`define RYA_OFS_ALARM_LAST 8'h18
`define RYA_OFS_CTRL       8'h1c

// ********************************************************************
// Field positions.
// ********************************************************************
`define RYA_CF_BIT  7
`define RYA_CIE_BIT 4
`define RYA_AIE_BIT 3
`define RYA_AF_BIT  0
`define RYA_ENB_BIT 7

// ********************************************************************
// Alarm field masks, reserved bits and reset values.
// ********************************************************************
`define RYA_NUM_ALARM  6
`define RYA_MASK_SEC   7'h7f
`define RYA_MASK_MIN   7'h7f
`define RYA_MASK_HOUR  7'h3f
`define RYA_MASK_WEEK  7'h07
`define RYA_MASK_DATE  7'h3f
`define RYA_MASK_MONTH 7'h1f
`define RYA_CTRL_RSVD  8'h66
`define RYA_CTRL_RST   8'h00
`define RYA_ENB_RST    1'b0
`define RYA_YEAR_MAX   8'h99

`endif

/* rya_pkg.sv */
`default_nettype none

package rya_pkg;

	typedef logic [7:0] rya_byte_t;

	typedef enum {
		RYA_SEL_NONE,
		RYA_SEL_YEAR,
		RYA_SEL_ALARM,
		RYA_SEL_CTRL
	} rya_sel_t;

endpackage

`default_nettype wire

/* rya_year_bcd.sv */
`include "rya_defs.svh"
`default_nettype none

module rya_year_bcd (
	// Clock and reset.
	input  wire logic              i_clk,
	input  wire logic              i_rst_n,
	// Load and advance.
	input  wire logic              i_load,
	input  wire rya_pkg::rya_byte_t i_load_data,
	input  wire logic              i_advance,
	input  wire logic              i_start,
	// Year state.
	output var  rya_pkg::rya_byte_t o_year,
	output var  logic              o_leap
);
	import rya_pkg::*;

	logic [3:0] tens;
	logic [3:0] ones;
	rya_byte_t  year_nxt;
	int         dec_val;

	assign tens = o_year[7:4];
	assign ones = o_year[3:0];

	always_comb begin
		if (ones == 4'h9) begin
			year_nxt = (tens == 4'h9) ? 8'h00 : {tens + 4'h1, 4'h0};
		end else begin
			year_nxt = {tens, ones + 4'h1};
		end
	end

	// No reset here: the year survives every reset. // [R4]
	always_ff @(posedge i_clk) begin
		if (i_load && !i_start) begin
			o_year <= i_load_data;
		end else if (i_advance && i_start) begin // [R20]
			o_year <= year_nxt; // [R1]
		end
	end

	// Divisible by four: even tens need 0/4/8, odd tens need 2/6.
	always_comb begin
		if (tens[0]) begin
			o_leap = (ones == 4'h2) || (ones == 4'h6); // [R3]
		end else begin
			o_leap = (ones == 4'h0) || (ones == 4'h4) || (ones == 4'h8);
		end
	end

	assign dec_val = int'(tens) * 10 + int'(ones);

	property p_year_wrap;
		@(posedge i_clk) disable iff (!i_rst_n)
		(o_year == `RYA_YEAR_MAX && i_advance && i_start && !i_load)
		|=> (o_year == 8'h00);
	endproperty
	a_year_wrap: assert property (p_year_wrap) // [R1]
		else $error("Year did not wrap from 99 to 00.");

	property p_year_halt;
		@(posedge i_clk) disable iff (!i_rst_n)
		(!i_start && !i_load) |=> $stable(o_year);
	endproperty
	a_year_halt: assert property (p_year_halt) // [R20]
		else $error("Year moved while counting was stopped.");

	property p_leap;
		@(posedge i_clk) disable iff (!i_rst_n)
		(tens < 4'ha && ones < 4'ha) |-> (o_leap == (dec_val % 4 == 0));
	endproperty
	a_leap: assert property (p_leap) // [R3]
		else $error("Leap year flag disagrees with year.");

endmodule

`default_nettype wire

/* rya_alarm_cmp.sv */
`default_nettype none

module rya_alarm_cmp #(
	parameter int N = 6,
	parameter int W = 7
) (
	// Compare enables and fields.
	input  wire logic [N-1:0]   i_enb,
	input  wire logic [N*W-1:0] i_field,
	input  wire logic [N*W-1:0] i_count,
	// Result.
	output var  logic           o_match
);
	import rya_pkg::*;

	logic [N-1:0] entry_ok;

	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_entry
			// A disabled entry never blocks the match. // [R5]
			assign entry_ok[g] = !i_enb[g] ||
				(i_field[g*W +: W] == i_count[g*W +: W]);
		end
	endgenerate

	// With no entry enabled there is nothing to match against. // [R6]
	assign o_match = (|i_enb) && (&entry_ok);

endmodule

`default_nettype wire

/* rya_top.sv */
// Behaviour
// [R1] BCD year counter advances on month carry.
// [R2] Software writes years 00-99 while stopped.
// [R3] Leap year when year divisible by four.
// [R4] No reset touches the year counter.
// [R5] Bit 7 enables comparing its alarm field.
// [R6] Alarm when all enabled fields match together.
// [R7] Software keeps alarm fields in BCD ranges.
// [R8] Weekday alarm field: three bits, codes 0-6.
// [R9] Power-on clears enables; fields keep values.
// [R10] Control resets to zero; manual keeps carry.
// [R11] Software avoids read-modify-write of control.
// [R12] Subsecond or second count-up sets carry flag.
// [R13] Writing 0 clears the carry flag.
// [R14] Writing 1 sets the carry flag.
// [R15] Reserved control bits read zero.
// [R16] Carry interrupt when flag and enable set.
// [R17] No alarm interrupt while enable is zero.
// [R18] Alarm interrupt when flag and enable set.
// [R19] Match sets alarm flag; write 0 clears.
// [R20] Start low halts year; high counts.
// [R21] Unused alarm upper bits read zero.
// [R22] Flag set on counter change giving match.
`include "rya_defs.svh"
`default_nettype none

module rya_top #(
	parameter int ADDR_W = 8
) (
	// Clock and power-on reset.
	input  wire logic               I_CLOCK,
	input  wire logic               I_RST_N,
	// Manual reset, same clock.
	input  wire logic               I_MANUAL_RST,
	// APB slave.
	input  wire logic               I_PSEL,
	input  wire logic               I_PENABLE,
	input  wire logic               I_PWRITE,
	input  wire logic [ADDR_W-1:0]  I_PADDR,
	input  wire logic [31:0]        I_PWDATA,
	output var  logic [31:0]        O_PRDATA,
	output var  logic               O_PREADY,
	output var  logic               O_PSLVERR,
	// Count events and start control.
	input  wire logic               I_COUNT_START,
	input  wire logic               I_SUBSEC_TICK,
	input  wire logic               I_SECOND_TICK,
	input  wire logic               I_MONTH_CARRY,
	// Calendar counters.
	input  wire rya_pkg::rya_byte_t I_SECOND_COUNT,
	input  wire rya_pkg::rya_byte_t I_MINUTE_COUNT,
	input  wire rya_pkg::rya_byte_t I_HOUR_COUNT,
	input  wire rya_pkg::rya_byte_t I_WEEKDAY_COUNT,
	input  wire rya_pkg::rya_byte_t I_DATE_COUNT,
	input  wire rya_pkg::rya_byte_t I_MONTH_COUNT,
	// Year state and interrupts.
	output var  rya_pkg::rya_byte_t O_YEAR_COUNT,
	output var  logic               O_LEAP_YEAR,
	output var  logic               O_CARRY_IRQ,
	output var  logic               O_ALARM_IRQ
);
	import rya_pkg::*;

	localparam int NA = `RYA_NUM_ALARM;
	localparam int FW = 7;
	localparam logic [FW-1:0] FIELD_MASK [NA] = '{
		`RYA_MASK_SEC,
		`RYA_MASK_MIN,
		`RYA_MASK_HOUR,
		`RYA_MASK_WEEK,
		`RYA_MASK_DATE,
		`RYA_MASK_MONTH
	};

	// ****************************************************************
	// Address decode.
	// ****************************************************************

	rya_sel_t          sel;
	logic [2:0]        alarm_idx;
	logic [ADDR_W-1:0] alarm_ofs;
	logic              aligned;
	logic              setup;
	logic              access;
	logic              wr;
	logic              year_wr;
	logic              alarm_wr;
	logic              ctrl_wr;

	assign aligned   = (I_PADDR[1:0] == 2'b00);
	assign alarm_ofs = I_PADDR - ADDR_W'(`RYA_OFS_ALARM0);
	assign alarm_idx = alarm_ofs[4:2];

	always_comb begin
		sel = RYA_SEL_NONE;
		if (!aligned) begin
			sel = RYA_SEL_NONE;
		end else if (I_PADDR == ADDR_W'(`RYA_OFS_YEAR)) begin
			sel = RYA_SEL_YEAR;
		end else if (I_PADDR >= ADDR_W'(`RYA_OFS_ALARM0) &&
				I_PADDR <= ADDR_W'(`RYA_OFS_ALARM_LAST)) begin
			sel = RYA_SEL_ALARM;
		end else if (I_PADDR == ADDR_W'(`RYA_OFS_CTRL)) begin
			sel = RYA_SEL_CTRL;
		end
	end

	assign setup    = I_PSEL && !I_PENABLE;
	assign access   = I_PSEL && I_PENABLE;
	assign wr       = access && I_PWRITE;
	assign year_wr  = wr && (sel == RYA_SEL_YEAR);
	assign alarm_wr = wr && (sel == RYA_SEL_ALARM);
	assign ctrl_wr  = wr && (sel == RYA_SEL_CTRL);

	// ****************************************************************
	// Year counter.
	// ****************************************************************

	// Year writes are ignored while counting runs, so a carry can never
	// race a software load.
	rya_year_bcd u_year (
		.i_clk       (I_CLOCK),
		.i_rst_n     (I_RST_N),
		.i_load      (year_wr),
		.i_load_data (I_PWDATA[7:0]),
		.i_advance   (I_MONTH_CARRY),
		.i_start     (I_COUNT_START),
		.o_year      (O_YEAR_COUNT),
		.o_leap      (O_LEAP_YEAR)
	);

	// ****************************************************************
	// Alarm registers and comparison.
	// ****************************************************************

	logic [FW-1:0]    alarm_field_r [NA];
	logic [NA-1:0]    alarm_enb_r;
	logic [FW-1:0]    cal [NA];
	logic [NA*FW-1:0] field_flat;
	logic [NA*FW-1:0] count_flat;
	logic [NA*FW-1:0] count_prev_r;
	logic             match;
	logic             cal_changed;
	logic             alarm_hit;

	assign cal[0] = I_SECOND_COUNT[6:0];
	assign cal[1] = I_MINUTE_COUNT[6:0];
	assign cal[2] = I_HOUR_COUNT[6:0];
	assign cal[3] = I_WEEKDAY_COUNT[6:0];
	assign cal[4] = I_DATE_COUNT[6:0];
	assign cal[5] = I_MONTH_COUNT[6:0];

	genvar g;
	generate
		for (g = 0; g < NA; g++) begin : g_alarm
			// Fields are never reset, only the enable bit is. // [R9]
			always_ff @(posedge I_CLOCK) begin
				if (alarm_wr && alarm_idx == 3'(g)) begin
					alarm_field_r[g] <= I_PWDATA[FW-1:0] & FIELD_MASK[g]; // [R21]
				end
			end
			always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
				if (!I_RST_N) begin
					alarm_enb_r[g] <= `RYA_ENB_RST; // [R9]
				end else if (alarm_wr && alarm_idx == 3'(g)) begin
					alarm_enb_r[g] <= I_PWDATA[`RYA_ENB_BIT]; // [R5]
				end
			end
			// Weekday keeps three bits through its mask. // [R8]
			assign field_flat[g*FW +: FW] = alarm_field_r[g];
			assign count_flat[g*FW +: FW] = cal[g] & FIELD_MASK[g];
		end
	endgenerate

	rya_alarm_cmp #(
		.N (NA),
		.W (FW)
	) u_cmp (
		.i_enb   (alarm_enb_r),
		.i_field (field_flat),
		.i_count (count_flat),
		.o_match (match)
	);

	always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			count_prev_r <= '0;
		end else begin
			count_prev_r <= count_flat;
		end
	end

	// A match is taken once per calendar change, so a standing match
	// that software has cleared does not set the flag again.
	assign cal_changed = (count_flat != count_prev_r); // [R22]
	assign alarm_hit   = cal_changed && match; // [R6]

	// ****************************************************************
	// Flag and control register.
	// ****************************************************************

	logic carry_flag_r;
	logic carry_irq_enable_r;
	logic alarm_irq_enable_r;
	logic alarm_flag_r;
	logic tick;

	assign tick = I_SUBSEC_TICK || I_SECOND_TICK;

	// Manual reset leaves the carry flag as it was.
	always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			carry_flag_r <= 1'(`RYA_CTRL_RST >> `RYA_CF_BIT); // [R10]
		end else if (tick) begin
			carry_flag_r <= 1'b1; // [R12]
		end else if (ctrl_wr) begin
			carry_flag_r <= I_PWDATA[`RYA_CF_BIT]; // [R13] [R14]
		end
	end

	always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			carry_irq_enable_r <= 1'b0;
			alarm_irq_enable_r <= 1'b0;
		end else if (I_MANUAL_RST) begin
			carry_irq_enable_r <= 1'b0; // [R10]
			alarm_irq_enable_r <= 1'b0;
		end else if (ctrl_wr) begin
			carry_irq_enable_r <= I_PWDATA[`RYA_CIE_BIT];
			alarm_irq_enable_r <= I_PWDATA[`RYA_AIE_BIT];
		end
	end

	always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			alarm_flag_r <= 1'b0;
		end else if (I_MANUAL_RST) begin
			alarm_flag_r <= 1'b0; // [R10]
		end else if (alarm_hit) begin
			alarm_flag_r <= 1'b1; // [R19] [R22]
		end else if (ctrl_wr && !I_PWDATA[`RYA_AF_BIT]) begin
			alarm_flag_r <= 1'b0; // [R19]
		end
	end

	assign O_CARRY_IRQ = carry_flag_r && carry_irq_enable_r; // [R16]
	assign O_ALARM_IRQ = alarm_flag_r && alarm_irq_enable_r; // [R17] [R18]

	// ****************************************************************
	// APB read path.
	// ****************************************************************

	rya_byte_t rd_byte;
	logic [31:0] prdata_r;
	logic        pslverr_r;

	always_comb begin
		rd_byte = 8'h00;
		case (sel)
			RYA_SEL_YEAR: begin
				rd_byte = O_YEAR_COUNT;
			end
			RYA_SEL_ALARM: begin
				rd_byte = {alarm_enb_r[alarm_idx], alarm_field_r[alarm_idx]};
			end
			RYA_SEL_CTRL: begin
				rd_byte = {carry_flag_r, 2'b00, carry_irq_enable_r,
					alarm_irq_enable_r, 2'b00, alarm_flag_r}; // [R15]
			end
			default: begin
				rd_byte = 8'h00;
			end
		endcase
	end

	// Data and error are caught in the setup cycle, so the access cycle
	// answers at once from flip-flops.
	always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			prdata_r  <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end else if (setup) begin
			prdata_r  <= {24'h00_0000, rd_byte};
			pslverr_r <= (sel == RYA_SEL_NONE);
		end
	end

	assign O_PRDATA  = prdata_r;
	assign O_PSLVERR = pslverr_r && access;
	assign O_PREADY  = access;

	// ****************************************************************
	// Checks.
	// ****************************************************************

	property p_carry_set;
		@(posedge I_CLOCK) disable iff (!I_RST_N)
		tick |=> carry_flag_r;
	endproperty
	a_carry_set: assert property (p_carry_set) // [R12]
		else $error("Count-up did not set the carry flag.");

	property p_carry_clr;
		@(posedge I_CLOCK) disable iff (!I_RST_N)
		(ctrl_wr && !I_PWDATA[`RYA_CF_BIT] && !tick) |=> !carry_flag_r;
	endproperty
	a_carry_clr: assert property (p_carry_clr) // [R13]
		else $error("Writing 0 did not clear the carry flag.");

	property p_carry_wr1;
		@(posedge I_CLOCK) disable iff (!I_RST_N)
		(ctrl_wr && I_PWDATA[`RYA_CF_BIT]) |=> carry_flag_r;
	endproperty
	a_carry_wr1: assert property (p_carry_wr1) // [R14]
		else $error("Writing 1 did not set the carry flag.");

	property p_rsvd_zero;
		@(posedge I_CLOCK) disable iff (!I_RST_N)
		(setup && sel == RYA_SEL_CTRL) |=>
		((O_PRDATA[7:0] & `RYA_CTRL_RSVD) == 8'h00);
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) // [R15]
		else $error("Reserved control bits read nonzero.");

	property p_carry_irq;
		@(posedge I_CLOCK) disable iff (!I_RST_N)
		(I_SECOND_TICK && carry_irq_enable_r && !I_MANUAL_RST && !ctrl_wr)
		|=> O_CARRY_IRQ;
	endproperty
	a_carry_irq: assert property (p_carry_irq) // [R16]
		else $error("Enabled carry did not raise its interrupt.");

	property p_alarm_irq_off;
		@(posedge I_CLOCK) disable iff (!I_RST_N)
		!alarm_irq_enable_r |-> !O_ALARM_IRQ;
	endproperty
	a_alarm_irq_off: assert property (p_alarm_irq_off) // [R17]
		else $error("Alarm interrupt raised while disabled.");

	property p_alarm_irq_on;
		@(posedge I_CLOCK) disable iff (!I_RST_N)
		(alarm_hit && alarm_irq_enable_r && !I_MANUAL_RST && !ctrl_wr)
		|=> O_ALARM_IRQ ##1
		(O_ALARM_IRQ || $past(ctrl_wr) || $past(I_MANUAL_RST));
	endproperty
	a_alarm_irq_on: assert property (p_alarm_irq_on) // [R18]
		else $error("Enabled alarm did not raise its interrupt.");

	property p_af_write_one;
		@(posedge I_CLOCK) disable iff (!I_RST_N)
		(ctrl_wr && I_PWDATA[`RYA_AF_BIT] && !alarm_flag_r && !alarm_hit)
		|=> !alarm_flag_r;
	endproperty
	a_af_write_one: assert property (p_af_write_one) // [R19]
		else $error("Writing 1 changed a clear alarm flag.");

	property p_af_cause;
		@(posedge I_CLOCK) disable iff (!I_RST_N)
		$rose(alarm_flag_r) |-> $past(cal_changed) && $past(match);
	endproperty
	a_af_cause: assert property (p_af_cause) // [R22]
		else $error("Alarm flag rose without a fresh full match.");

	property p_manual_rst;
		@(posedge I_CLOCK) disable iff (!I_RST_N)
		I_MANUAL_RST |=> !carry_irq_enable_r && !alarm_irq_enable_r &&
		!alarm_flag_r;
	endproperty
	a_manual_rst: assert property (p_manual_rst) // [R10]
		else $error("Manual reset left control bits set.");

	property p_hour_upper;
		@(posedge I_CLOCK) disable iff (!I_RST_N)
		(setup && sel == RYA_SEL_ALARM && alarm_idx == 3'd2) |=>
		(O_PRDATA[6] == 1'b0);
	endproperty
	a_hour_upper: assert property (p_hour_upper) // [R21]
		else $error("Unused hour alarm bit read nonzero.");

endmodule

`default_nettype wire

/* rya_top_bench.sv */
`include "rya_defs.svh"
`default_nettype none

// ********************************************************************
// Comparison helpers.
// ********************************************************************
`define CHK(got, exp) begin \
	n_checks++; \
	if ((got) !== (exp)) begin \
		error_cnt++; \
		$display("ERROR t=%0t got %h exp %h", $time, (got), (exp)); \
	end \
end
`define RCHK(a, e) begin \
	apb(1'b0, a, 8'h00); \
	`CHK(rd, {24'h000000, e}) \
end

module rya_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import rya_pkg::*;

	// ********************************************************************
	// Signals.
	// ********************************************************************
	logic        clk;
	logic        rst_n;
	logic        man_rst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        start;
	logic        sub_tick;
	logic        sec_tick;
	logic        mon_carry;
	rya_byte_t   cnt [6];
	rya_byte_t   year;
	logic        leap;
	logic        cirq;
	logic        airq;
	int          error_cnt;
	int          n_checks;
	logic [31:0] rd;
	logic        er;

	rya_top rya_top_i (
		.I_CLOCK         (clk),
		.I_RST_N         (rst_n),
		.I_MANUAL_RST    (man_rst),
		.I_PSEL          (psel),
		.I_PENABLE       (penable),
		.I_PWRITE        (pwrite),
		.I_PADDR         (paddr),
		.I_PWDATA        (pwdata),
		.O_PRDATA        (prdata),
		.O_PREADY        (pready),
		.O_PSLVERR       (pslverr),
		.I_COUNT_START   (start),
		.I_SUBSEC_TICK   (sub_tick),
		.I_SECOND_TICK   (sec_tick),
		.I_MONTH_CARRY   (mon_carry),
		.I_SECOND_COUNT  (cnt[0]),
		.I_MINUTE_COUNT  (cnt[1]),
		.I_HOUR_COUNT    (cnt[2]),
		.I_WEEKDAY_COUNT (cnt[3]),
		.I_DATE_COUNT    (cnt[4]),
		.I_MONTH_COUNT   (cnt[5]),
		.O_YEAR_COUNT    (year),
		.O_LEAP_YEAR     (leap),
		.O_CARRY_IRQ     (cirq),
		.O_ALARM_IRQ     (airq)
	);

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// ********************************************************************
	// Shared tasks.
	// ********************************************************************
	task automatic print_verdict;
		if (error_cnt == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Entered just after a rising edge; returns just after one.
	task automatic apb(input logic w, input logic [7:0] a,
			input logic [7:0] d);
		int k;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= {24'h000000, d};
		@(posedge clk);
		penable <= 1'b1;
		for (k = 0; k < 16; k++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		if (k == 16) begin
			error_cnt++;
			print_verdict();
		end
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task automatic pulse(input int which);
		case (which)
			0: sub_tick <= 1'b1;
			1: sec_tick <= 1'b1;
			default: mon_carry <= 1'b1;
		endcase
		@(posedge clk);
		sub_tick  <= 1'b0;
		sec_tick  <= 1'b0;
		mon_carry <= 1'b0;
		@(posedge clk);
	endtask

	task automatic settle;
		repeat (2) @(posedge clk);
	endtask

	// ********************************************************************
	// Scenarios.
	// ********************************************************************
	task automatic t_reset_values;
		`RCHK(`RYA_OFS_CTRL, 8'h00);
		for (int i = 0; i < 6; i++) begin
			apb(1'b0, 8'(`RYA_OFS_ALARM0 + 4 * i), 8'h00);
			`CHK(rd[7], 1'b0);
		end
		`CHK(cirq, 1'b0);
		`CHK(airq, 1'b0);
	endtask

	// Fields stay in their legal ranges; beyond them only the enable bit carries ones, and unused upper bits read back zero.
	task automatic t_alarm_masks;
		logic [7:0] w [6] = '{8'hd9, 8'hc5, 8'he3, 8'hfe, 8'hf1, 8'hf2};
		logic [7:0] x [6] = '{8'hd9, 8'hc5, 8'ha3, 8'h86, 8'hb1, 8'h92};
		logic [7:0] a;
		for (int i = 0; i < 6; i++) begin
			a = 8'(`RYA_OFS_ALARM0 + 4 * i);
			apb(1'b1, a, w[i]);
			`RCHK(a, x[i]);
			apb(1'b1, a, 8'h01);
		end
	endtask

	task automatic t_ctrl_carry;
		apb(1'b1, `RYA_OFS_CTRL, 8'h99);
		`RCHK(`RYA_OFS_CTRL, 8'h98);
		`CHK(cirq, 1'b1);
		apb(1'b1, `RYA_OFS_CTRL, 8'h10);
		`RCHK(`RYA_OFS_CTRL, 8'h10);
		`CHK(cirq, 1'b0);
		pulse(0);
		`CHK(cirq, 1'b1);
		apb(1'b1, `RYA_OFS_CTRL, 8'h00);
		pulse(1);
		`RCHK(`RYA_OFS_CTRL, 8'h80);
		`CHK(cirq, 1'b0);
		apb(1'b1, `RYA_OFS_CTRL, 8'h00);
	endtask

	task automatic t_alarm_match;
		apb(1'b1, `RYA_OFS_CTRL, 8'h08);
		cnt[0] <= 8'h30;
		cnt[5] <= 8'h11;
		apb(1'b1, `RYA_OFS_ALARM0, 8'hb0);
		apb(1'b1, `RYA_OFS_ALARM_LAST, 8'h92);
		settle();
		`CHK(airq, 1'b0);
		cnt[5] <= 8'h12;
		settle();
		`CHK(airq, 1'b1);
		apb(1'b1, `RYA_OFS_CTRL, 8'h09);
		`RCHK(`RYA_OFS_CTRL, 8'h09);
		apb(1'b1, `RYA_OFS_CTRL, 8'h08);
		`RCHK(`RYA_OFS_CTRL, 8'h08);
		// A standing match must not re-raise a cleared flag.
		`CHK(airq, 1'b0);
		apb(1'b1, `RYA_OFS_ALARM_LAST, 8'h12);
		cnt[5] <= 8'h05;
		cnt[0] <= 8'h31;
		settle();
		`CHK(airq, 1'b0);
		cnt[0] <= 8'h30;
		settle();
		`CHK(airq, 1'b1);
		apb(1'b1, `RYA_OFS_CTRL, 8'h00);
	endtask

	task automatic t_weekday;
		cnt[3] <= 8'h07;
		settle();
		for (int k = 0; k < 7; k++) begin
			apb(1'b1, 8'h10, 8'h80 | 8'(k));
			apb(1'b1, `RYA_OFS_CTRL, 8'h00);
			cnt[3] <= 8'(k);
			settle();
			`RCHK(`RYA_OFS_CTRL, 8'h01);
			`CHK(airq, 1'b0);
		end
		apb(1'b1, 8'h10, 8'h00);
		apb(1'b1, `RYA_OFS_CTRL, 8'h00);
	endtask

	task automatic t_year;
		logic [7:0] y [5] = '{8'h10, 8'h12, 8'h96, 8'h98, 8'h99};
		logic       l [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
		start <= 1'b0;
		for (int i = 0; i < 5; i++) begin
			apb(1'b1, `RYA_OFS_YEAR, y[i]);
			`CHK(year, y[i]);
			`CHK(leap, l[i]);
		end
		pulse(2);
		`CHK(year, 8'h99);
		start <= 1'b1;
		pulse(2);
		`CHK(year, 8'h00);
		`CHK(leap, 1'b1);
		pulse(2);
		`RCHK(`RYA_OFS_YEAR, 8'h01);
		start <= 1'b0;
		pulse(2);
		`CHK(year, 8'h01);
	endtask

	task automatic t_resets;
		apb(1'b1, `RYA_OFS_ALARM0, 8'hb0);
		apb(1'b1, `RYA_OFS_CTRL, 8'h18);
		man_rst <= 1'b1;
		@(posedge clk);
		man_rst <= 1'b0;
		@(posedge clk);
		apb(1'b0, `RYA_OFS_CTRL, 8'h00);
		`CHK(rd[6:0], 7'h00);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		`CHK(year, 8'h01);
		`RCHK(`RYA_OFS_ALARM0, 8'h30);
		`RCHK(`RYA_OFS_CTRL, 8'h00);
		apb(1'b0, 8'h20, 8'h00);
		`CHK(er, 1'b1);
	endtask

	// ********************************************************************
	// Main sequence.
	// ********************************************************************
	initial begin
		error_cnt = 0;
		n_checks  = 0;
		rst_n     = 1'b0;
		man_rst   = 1'b0;
		psel      = 1'b0;
		penable   = 1'b0;
		pwrite    = 1'b0;
		paddr     = 8'h00;
		pwdata    = 32'h00000000;
		start     = 1'b0;
		sub_tick  = 1'b0;
		sec_tick  = 1'b0;
		mon_carry = 1'b0;
		for (int i = 0; i < 6; i++) cnt[i] = 8'h00;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_reset_values();
		t_alarm_masks();
		t_ctrl_carry();
		t_alarm_match();
		t_weekday();
		t_year();
		t_resets();
		print_verdict();
	end
endmodule

`default_nettype wire
